// file: include/pbc_consts.svh
// Register map, field positions, reset values and timing for the gain block
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH
// ==========================================================
// Widths
`define PBC_ADDR_W 16
`define PBC_DATA_W 8
`define PBC_CNT_W 20
`define PBC_REG_N 7
// ==========================================================
// Register indices into the storage array
`define PBC_IDX_AMP3 0
`define PBC_IDX_SLEW 1
`define PBC_IDX_BOOST 2
`define PBC_IDX_CHG 3
`define PBC_IDX_PATH 4
`define PBC_IDX_LVL0 5
`define PBC_IDX_STAT 6
// ==========================================================
// Byte offsets
`define PBC_OFS_AMP3 16'h0026
`define PBC_OFS_SLEW 16'h0027
`define PBC_OFS_BOOST 16'h0028
`define PBC_OFS_CHG 16'h0029
`define PBC_OFS_PATH 16'h002A
`define PBC_OFS_LVL0 16'h002B
`define PBC_OFS_STAT 16'h0040
// ==========================================================
// Reset values and writable masks
`define PBC_RST_AMP3 8'h40
`define PBC_RST_SLEW 8'h00
`define PBC_RST_BOOST 8'h00
`define PBC_RST_CHG 8'h3F
`define PBC_RST_PATH 8'h00
`define PBC_RST_LVL0 8'h00
`define PBC_MSK_AMP3 8'hFF
`define PBC_MSK_SLEW 8'h3F
`define PBC_MSK_BOOST 8'h0F
`define PBC_MSK_CHG 8'h3F
`define PBC_MSK_PATH 8'h03
`define PBC_MSK_LVL0 8'hFF
`define PBC_MSK_NONE 8'h00
// ==========================================================
// Field positions
`define PBC_MIC_BIT 7
`define PBC_MUTE_BIT 6
`define PBC_GAIN_MSB 5
`define PBC_RATE_MSB 5
`define PBC_RATE_LSB 4
`define PBC_AMP_MSB 3
`define PBC_OUT_MSB 5
`define PBC_OUT_LSB 4
`define PBC_ROUTE_MSB 1
`define PBC_BUSY_BIT 7
`define PBC_BOOST3_BIT 3
`define PBC_OFF3_BIT 3
// ==========================================================
// Timing and gain arithmetic
`define PBC_CLK_MHZ 25
`define PBC_SLEW0_US 21500
`define PBC_SLEW1_US 42500
`define PBC_SLEW2_US 85000
`define PBC_RAMP_STEPS 64
`define PBC_GAIN_STEP_Q 3
`define PBC_GAIN_BASE_Q 48
`define PBC_BOOST_Q 40
`endif

// file: include/pbc_pkg.sv
// Types shared by the gain block modules
package pbc_pkg;
   // ==========================================================
   // Ramp engine states
   typedef enum logic [0:0] {
      ramp_idle = 1'b0,
      ramp_run = 1'b1
   } pbc_ramp_state_type;
   // ==========================================================
   // Slew rate codes
   typedef enum logic [1:0] {
      rate_21ms = 2'b00,
      rate_42ms = 2'b01,
      rate_85ms = 2'b10,
      rate_rsvd = 2'b11
   } pbc_rate_type;
endpackage : pbc_pkg

// file: include/pbc_ramp_if.sv
// Link between the register block and the gain ramp engine
`timescale 1ns/1ps
`include "pbc_consts.svh"
interface pbc_ramp_if;
   logic [`PBC_GAIN_MSB:0] target;
   logic hold;
   logic jump;
   logic [`PBC_CNT_W-1:0] interval;
   logic [`PBC_GAIN_MSB:0] applied;
   logic busy;
   modport ctl (
      output target,
      output hold,
      output jump,
      output interval,
      input applied,
      input busy
   );
   modport eng (
      input target,
      input hold,
      input jump,
      input interval,
      output applied,
      output busy
   );
endinterface : pbc_ramp_if

// file: rtl/pbc_ramp.sv
// Gain ramp engine: walks the applied gain code toward its target
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_ramp (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control link
   pbc_ramp_if.eng rif
);
   // ==========================================================
   // State
   pbc_pkg::pbc_ramp_state_type state_ff, nxt_state;
   logic [`PBC_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [`PBC_GAIN_MSB:0] code_ff, nxt_code;
   wire at_target = code_ff == rif.target;
   wire [`PBC_CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;
   wire step_due = cnt_inc >= rif.interval;
   wire go_up = rif.target > code_ff;
   // ==========================================================
   // Next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_code = code_ff;
      if (rif.hold) begin
         // Muted: gain field ignored, applied code frozen
         nxt_state = pbc_pkg::ramp_idle;
         nxt_cnt = '0;
      end else if (rif.jump) begin
         // No slewing: take the new code at once
         nxt_state = pbc_pkg::ramp_idle;
         nxt_cnt = '0;
         nxt_code = rif.target;
      end else begin
         unique case (state_ff)
            pbc_pkg::ramp_idle: begin
               if (!at_target) begin
                  nxt_state = pbc_pkg::ramp_run;
                  nxt_cnt = '0;
               end
            end
            pbc_pkg::ramp_run: begin
               if (at_target) begin
                  nxt_state = pbc_pkg::ramp_idle;
               end else if (step_due) begin
                  // One code step per interval
                  nxt_cnt = '0;
                  nxt_code = go_up ? code_ff + 1'b1 : code_ff - 1'b1;
               end else begin
                  nxt_cnt = cnt_inc;
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= pbc_pkg::ramp_idle;
         cnt_ff <= '0;
         code_ff <= '0;
      end else if (ce) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         code_ff <= nxt_code;
      end
   end
   assign rif.applied = code_ff;
   assign rif.busy = state_ff == pbc_pkg::ramp_run;
   // ==========================================================
   // Checks
   step_wait_a: assert property (@(posedge clk) disable iff (rst)
      ce && !rif.hold && !rif.jump && state_ff == pbc_pkg::ramp_run
      && !step_due |=> code_ff == $past(code_ff))
      else $error("ramp stepped before interval");
   step_take_a: assert property (@(posedge clk) disable iff (rst)
      ce && !rif.hold && !rif.jump && state_ff == pbc_pkg::ramp_run
      && step_due && !at_target |=> code_ff != $past(code_ff))
      else $error("ramp missed a due step");
endmodule : pbc_ramp

// file: rtl/pbc_top.sv
// Input gain, slew, boost, click guard and bypass control registers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_top #(
   parameter int unsigned SLEW0_CYC =
      (`PBC_SLEW0_US * `PBC_CLK_MHZ) / `PBC_RAMP_STEPS,
   parameter int unsigned SLEW1_CYC =
      (`PBC_SLEW1_US * `PBC_CLK_MHZ) / `PBC_RAMP_STEPS,
   parameter int unsigned SLEW2_CYC =
      (`PBC_SLEW2_US * `PBC_CLK_MHZ) / `PBC_RAMP_STEPS
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [`PBC_ADDR_W-1:0] addr,
   input wire logic [`PBC_DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [`PBC_DATA_W-1:0] rdata,
   // Input amplifier 3
   output logic amp3_mic_select,
   output logic amp3_silence,
   output logic [`PBC_GAIN_MSB:0] amp3_gain_applied,
   output logic [8:0] amp3_gain_qdb,
   output logic amp3_ramp_busy,
   // Shared amplifier controls
   output logic [1:0] slew_rate_code,
   output logic [`PBC_AMP_MSB:0] amp_ramp_off,
   output logic [`PBC_AMP_MSB:0] amp_slew_active,
   output logic [`PBC_AMP_MSB:0] amp_extra_gain,
   // Click guards
   output logic [1:0] out_click_guard_off,
   output logic [`PBC_AMP_MSB:0] in_click_guard_off,
   // Bypass path
   output logic [`PBC_ROUTE_MSB:0] bypass_route,
   output logic dac0_bypass,
   output logic dac1_bypass,
   output logic [`PBC_DATA_W-1:0] bypass_out0_level
);
   // ==========================================================
   // Register table
   localparam int REG_N = `PBC_REG_N;
   localparam logic [`PBC_ADDR_W-1:0] REG_OFS [REG_N] = '{
      `PBC_OFS_AMP3, `PBC_OFS_SLEW, `PBC_OFS_BOOST, `PBC_OFS_CHG,
      `PBC_OFS_PATH, `PBC_OFS_LVL0, `PBC_OFS_STAT};
   localparam logic [`PBC_DATA_W-1:0] REG_RST [REG_N] = '{
      `PBC_RST_AMP3, `PBC_RST_SLEW, `PBC_RST_BOOST, `PBC_RST_CHG,
      `PBC_RST_PATH, `PBC_RST_LVL0, `PBC_MSK_NONE};
   // Masks keep reserved bits at zero
   localparam logic [`PBC_DATA_W-1:0] REG_MSK [REG_N] = '{
      `PBC_MSK_AMP3, `PBC_MSK_SLEW, `PBC_MSK_BOOST, `PBC_MSK_CHG,
      `PBC_MSK_PATH, `PBC_MSK_LVL0, `PBC_MSK_NONE};
   // ==========================================================
   // Storage and decode
   logic [`PBC_DATA_W-1:0] reg_ff [REG_N];
   logic [`PBC_DATA_W-1:0] rd_term [REG_N];
   logic [REG_N-1:0] hit;
   logic [`PBC_DATA_W-1:0] status_word;
   genvar gi;
   generate
      for (gi = 0; gi < REG_N; gi++) begin : g_reg
         assign hit[gi] = addr == REG_OFS[gi];
         // Status word is live state, not storage
         assign rd_term[gi] = !hit[gi] ? '0 :
            (gi == `PBC_IDX_STAT) ? status_word : reg_ff[gi];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               reg_ff[gi] <= REG_RST[gi];
            end else if (ce && wr_stb && hit[gi]) begin
               reg_ff[gi] <= wdata & REG_MSK[gi];
            end
         end
      end
   endgenerate
   // ==========================================================
   // Field views
   wire [`PBC_DATA_W-1:0] amp3_reg = reg_ff[`PBC_IDX_AMP3];
   wire [`PBC_DATA_W-1:0] slew_reg = reg_ff[`PBC_IDX_SLEW];
   wire [`PBC_DATA_W-1:0] boost_reg = reg_ff[`PBC_IDX_BOOST];
   wire [`PBC_DATA_W-1:0] chg_reg = reg_ff[`PBC_IDX_CHG];
   wire [`PBC_DATA_W-1:0] path_reg = reg_ff[`PBC_IDX_PATH];
   wire [`PBC_DATA_W-1:0] lvl0_reg = reg_ff[`PBC_IDX_LVL0];
   wire amp3_mic_bit = amp3_reg[`PBC_MIC_BIT];
   wire amp3_mute_bit = amp3_reg[`PBC_MUTE_BIT];
   wire [`PBC_GAIN_MSB:0] amp3_gain_code = amp3_reg[`PBC_GAIN_MSB:0];
   wire [1:0] rate_field = slew_reg[`PBC_RATE_MSB:`PBC_RATE_LSB];
   wire [`PBC_AMP_MSB:0] ramp_off_field = slew_reg[`PBC_AMP_MSB:0];
   wire [`PBC_AMP_MSB:0] boost_field = boost_reg[`PBC_AMP_MSB:0];
   wire [`PBC_ROUTE_MSB:0] route_field = path_reg[`PBC_ROUTE_MSB:0];
   // ==========================================================
   // Ramp engine for amplifier 3
   pbc_ramp_if rif ();
   // Reserved rate code falls back to the slowest ramp
   wire [`PBC_CNT_W-1:0] slew_interval =
      (rate_field == pbc_pkg::rate_21ms) ? `PBC_CNT_W'(SLEW0_CYC) :
      (rate_field == pbc_pkg::rate_42ms) ? `PBC_CNT_W'(SLEW1_CYC) :
      `PBC_CNT_W'(SLEW2_CYC);
   assign rif.target = amp3_gain_code;
   assign rif.hold = amp3_mute_bit;
   // Line input powers the amp down, so no slewing there
   assign rif.jump = ramp_off_field[`PBC_OFF3_BIT] | ~amp3_mic_bit;
   assign rif.interval = slew_interval;
   pbc_ramp u_ramp (
      .clk (clk),
      .rst (rst),
      .ce (ce),
      .rif (rif.eng)
   );
   assign status_word = {rif.busy, 1'b0, rif.applied};
   // ==========================================================
   // Derived outputs
   logic [8:0] gain_qdb_ff, nxt_gain_qdb;
   logic dac0_byp_ff, dac1_byp_ff;
   logic [`PBC_DATA_W-1:0] lvl_out_ff, nxt_lvl_out;
   logic [`PBC_DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [`PBC_AMP_MSB:0] slew_act_ff;
   wire [8:0] base_qdb =
      9'({3'b000, rif.applied} * 9'(`PBC_GAIN_STEP_Q))
      - 9'(`PBC_GAIN_BASE_Q);
   wire [8:0] boost_qdb =
      boost_field[`PBC_BOOST3_BIT] ? 9'(`PBC_BOOST_Q) : 9'h000;
   assign nxt_gain_qdb = base_qdb + boost_qdb;
   // Level only reaches DAC0 while bypass feeds it
   assign nxt_lvl_out = route_field[0] ? lvl0_reg : '0;
   always_comb begin
      nxt_rdata = '0;
      for (int i = 0; i < REG_N; i++) begin
         nxt_rdata = nxt_rdata | rd_term[i];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gain_qdb_ff <= '0;
         lvl_out_ff <= '0;
         dac0_byp_ff <= 1'b0;
         dac1_byp_ff <= 1'b0;
      end else if (ce) begin
         gain_qdb_ff <= nxt_gain_qdb;
         lvl_out_ff <= nxt_lvl_out;
         dac0_byp_ff <= route_field[0];
         dac1_byp_ff <= route_field[1];
      end
   end
   // Read data stands for one cycle only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (ce) begin
         rdata_ff <= rd_stb ? nxt_rdata : '0;
      end
   end
   generate
      for (gi = 0; gi <= `PBC_AMP_MSB; gi++) begin : g_amp
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               slew_act_ff[gi] <= 1'b1;
            end else if (ce) begin
               slew_act_ff[gi] <= ~ramp_off_field[gi];
            end
         end
      end
   endgenerate
   // ==========================================================
   // Output wiring
   assign rdata = rdata_ff;
   assign amp3_mic_select = amp3_mic_bit;
   assign amp3_silence = amp3_mute_bit;
   assign amp3_gain_applied = rif.applied;
   assign amp3_gain_qdb = gain_qdb_ff;
   assign amp3_ramp_busy = rif.busy;
   assign slew_rate_code = rate_field;
   assign amp_ramp_off = ramp_off_field;
   assign amp_slew_active = slew_act_ff;
   assign amp_extra_gain = boost_field;
   assign out_click_guard_off = chg_reg[`PBC_OUT_MSB:`PBC_OUT_LSB];
   assign in_click_guard_off = chg_reg[`PBC_AMP_MSB:0];
   assign bypass_route = route_field;
   assign dac0_bypass = dac0_byp_ff;
   assign dac1_bypass = dac1_byp_ff;
   assign bypass_out0_level = lvl_out_ff;
   // ==========================================================
   // Checks
   wire wr_amp3 = ce && wr_stb && hit[`PBC_IDX_AMP3];
   wire wr_chg = ce && wr_stb && hit[`PBC_IDX_CHG];
   wire wr_path = ce && wr_stb && hit[`PBC_IDX_PATH];
   line_track_a: assert property (@(posedge clk) disable iff (rst)
      ce && !amp3_mute_bit && !amp3_mic_bit
      |=> rif.applied == $past(amp3_gain_code))
      else $error("line mode gain not taken at once");
   mic_slew_a: assert property (@(posedge clk) disable iff (rst)
      ce && amp3_mic_bit && !amp3_mute_bit
      && !ramp_off_field[`PBC_OFF3_BIT]
      |=> (rif.applied == $past(rif.applied))
      || (rif.applied == $past(rif.applied) + 6'h01)
      || (rif.applied == $past(rif.applied) - 6'h01))
      else $error("mic mode gain jumped more than a step");
   mute_freeze_a: assert property (@(posedge clk) disable iff (rst)
      ce && amp3_mute_bit |=> rif.applied == $past(rif.applied))
      else $error("gain moved while muted");
   mute_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_amp3 |=> amp3_silence == $past(wdata[`PBC_MUTE_BIT])
      && amp3_mic_select == $past(wdata[`PBC_MIC_BIT]))
      else $error("amp3 control write not taken");
   reset_vals_a: assert property (@(posedge clk)
      $fell(rst) |-> amp3_silence && out_click_guard_off == 2'h3
      && in_click_guard_off == 4'hF && bypass_route == 2'h0
      && bypass_out0_level == 8'h00)
      else $error("bad values after reset");
   // Skip the release edge, the gain flop is still held in reset there
   gain_base_a: assert property (@(posedge clk) disable iff (rst)
      ce && !rst && !boost_field[`PBC_BOOST3_BIT] ##1 ce
      |-> amp3_gain_qdb == 9'($past(rif.applied) * 9'h003) - 9'h030)
      else $error("gain scale wrong");
   jump_off_a: assert property (@(posedge clk) disable iff (rst)
      ce && !amp3_mute_bit && ramp_off_field[`PBC_OFF3_BIT]
      |=> rif.applied == $past(amp3_gain_code) && !rif.busy)
      else $error("ramp off did not jump");
   boost_add_a: assert property (@(posedge clk) disable iff (rst)
      ce && boost_field[`PBC_BOOST3_BIT]
      |=> amp3_gain_qdb == $past(base_qdb) + 9'h028)
      else $error("boost not added");
   guard_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_chg |=> out_click_guard_off == $past(wdata[5:4])
      && in_click_guard_off == $past(wdata[3:0]))
      else $error("click guard write lost");
   route_out_a: assert property (@(posedge clk) disable iff (rst)
      wr_path ##1 ce |=> dac0_bypass == $past(wdata[0], 2)
      && dac1_bypass == $past(wdata[1], 2))
      else $error("bypass route decode wrong");
   level_gate_a: assert property (@(posedge clk) disable iff (rst)
      ce |=> bypass_out0_level == ($past(route_field[0])
      ? $past(lvl0_reg) : 8'h00))
      else $error("bypass level gate wrong");
   resv_zero_a: assert property (@(posedge clk) disable iff (rst)
      ce && rd_stb && (hit[`PBC_IDX_PATH] || hit == '0)
      |=> rdata[7:2] == 6'h00)
      else $error("reserved bits read nonzero");
endmodule : pbc_top

// file: bench/tb_top.sv
// Self-checking bench for the gain, click guard and bypass registers
`timescale 1ns/1ps
`include "pbc_consts.svh"
module tb_top;
   // ==========================================================
   // Signals and model state
   localparam int I0 = 4;
   localparam int I1 = 6;
   localparam int I2 = 8;
   localparam int LIMIT = 80000;
   logic clk, rst, ce, wr_stb, rd_stb;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, lvl;
   logic mic, sil, busy, d0, d1;
   logic [5:0] app_o;
   logic [8:0] qdb;
   logic [1:0] rate, og, route;
   logic [3:0] roff, sact, xg, ig;
   logic [7:0] m [6];
   logic [7:0] msk [6] = '{8'hff, 8'h3f, 8'h0f, 8'h3f, 8'h03, 8'hff};
   logic [7:0] rstv [6] = '{8'h40, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00};
   int iv [4] = '{I0, I1, I2, I2};
   int app, n, err_count, comparisons, cyc, seed;
   logic [15:0] a;
   // ==========================================================
   // Design
   pbc_top #(.SLEW0_CYC(I0), .SLEW1_CYC(I1), .SLEW2_CYC(I2)) i_dut (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .amp3_mic_select(mic), .amp3_silence(sil),
      .amp3_gain_applied(app_o), .amp3_gain_qdb(qdb),
      .amp3_ramp_busy(busy), .slew_rate_code(rate), .amp_ramp_off(roff),
      .amp_slew_active(sact), .amp_extra_gain(xg),
      .out_click_guard_off(og), .in_click_guard_off(ig),
      .bypass_route(route), .dac0_bypass(d0), .dac1_bypass(d1),
      .bypass_out0_level(lvl)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // Checking and bus tasks
   task end_of_test;
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         end_of_test;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function int idx(input logic [15:0] ad);
      return (ad >= 16'h0026 && ad <= 16'h002b) ? int'(ad - 16'h0026) : -1;
   endfunction : idx
   task wr(input logic [15:0] ad, input logic [7:0] d);
      int k;
      k = idx(ad);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      if (k >= 0)
         m[k] = d & msk[k];
      if (m[0][6] == 1'b0)
         app = m[0][5:0];
   endtask : wr
   task rd(input logic [15:0] ad);
      logic [7:0] e;
      int k;
      k = idx(ad);
      e = (k >= 0) ? m[k] : (ad == 16'h0040) ? 8'(app) : 8'h00;
      @(posedge clk);
      addr <= ad;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(16'(rdata), 16'(e));
      @(posedge clk);
      #1 chk(16'(rdata), 16'h0000);
   endtask : rd
   // Compares every field output with the model once the ramp is idle
   task chk_out;
      int q;
      @(posedge clk);
      #1;
      q = app * 3 - 48 + (m[2][3] ? 40 : 0);
      chk(16'(mic), 16'(m[0][7]));
      chk(16'(sil), 16'(m[0][6]));
      chk(16'(app_o), 16'(app));
      chk(16'(qdb), 16'(q & 511));
      chk(16'(rate), 16'(m[1][5:4]));
      chk(16'(roff), 16'(m[1][3:0]));
      chk(16'(sact), 16'(m[1][3:0] ^ 4'hf));
      chk(16'(busy), 16'h0000);
      chk(16'(xg), 16'(m[2][3:0]));
      chk(16'(og), 16'(m[3][5:4]));
      chk(16'(ig), 16'(m[3][3:0]));
      chk(16'(route), 16'(m[4][1:0]));
      chk(16'(d0), 16'(m[4][0]));
      chk(16'(d1), 16'(m[4][1]));
      chk(16'(lvl), m[4][0] ? 16'(m[5]) : 16'h0000);
   endtask : chk_out
   // Bounded wait for the ramp to finish, returns cycles since the write
   task settle(output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while (cnt < 1000 && (cnt < 3 || busy !== 1'b0));
      if (cnt >= 1000) begin
         err_count++;
         $display("BAD %0t ramp never settled", $time);
      end
      chk_out;
   endtask : settle
   task do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      m = rstv;
      app = 0;
      for (int i = 0; i < 6; i++)
         rd(16'h0026 + 16'(i));
      rd(16'h0040);
      chk_out;
   endtask : do_reset
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      addr = 16'h0000;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      err_count = 0;
      comparisons = 0;
      cyc = 0;
      seed = 32'hb1ed;
      do_reset;
      // All ones then all zeros, reserved bits dropped
      for (int v = 0; v < 2; v++) begin
         for (int i = 0; i < 6; i++) begin
            wr(16'h0026 + 16'(i), v ? 8'h00 : 8'hff);
            settle(n);
            rd(16'h0026 + 16'(i));
         end
      end
      // Unmapped and read-only places
      wr(16'h002c, 8'hff);
      rd(16'h002c);
      wr(16'h0040, 8'hff);
      rd(16'h0040);
      rd(16'h0025);
      // Gain code ends with ramp off, plain and boosted
      wr(16'h0027, 8'h08);
      for (int b = 0; b < 2; b++) begin
         wr(16'h0028, b ? 8'h08 : 8'h00);
         foreach (iv[j]) begin
            wr(16'h0026, 8'h80 | 8'(j * 21));
            settle(n);
            chk(16'(n <= 3), 16'h0001);
         end
         wr(16'h0026, 8'h80 | 8'h3f);
         settle(n);
      end
      // Mute freezes the applied code
      wr(16'h0026, 8'h94);
      settle(n);
      wr(16'h0026, 8'hf0);
      settle(n);
      // Slew rates with the ramp on, up and down by eight codes
      wr(16'h0027, 8'h00);
      wr(16'h0026, 8'h80);
      settle(n);
      for (int r = 0; r < 4; r++) begin
         wr(16'h0027, 8'(r << 4));
         wr(16'h0026, 8'h80 | ((r % 2 == 0) ? 8'h08 : 8'h00));
         settle(n);
         chk(16'(n >= 8 * iv[r] && n <= 8 * iv[r] + 4), 16'h0001);
      end
      // Line input tracks without slew
      wr(16'h0026, 8'h0a);
      settle(n);
      chk(16'(n <= 3), 16'h0001);
      rd(16'h0040);
      // Every bypass route with a random level
      for (int r = 0; r < 4; r++) begin
         wr(16'h002b, 8'($random(seed)));
         wr(16'h002a, 8'(r));
         settle(n);
      end
      // Strobe ignored while the clock enable is low
      @(posedge clk);
      ce <= 1'b0;
      addr <= 16'h002b;
      wdata <= ~m[5];
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      ce <= 1'b1;
      rd(16'h002b);
      // Random traffic, unmapped places included
      repeat (40) begin
         a = 16'h0026 + 16'($random(seed) & 7);
         wr(a, 8'($random(seed)));
         settle(n);
         rd(a);
      end
      do_reset;
      end_of_test;
   end
endmodule : tb_top
